/* File: rtl/ccprc_pkg.sv */
// Summary of operation
// - Start-ratio pins pick 8, 32 or 16 ratio
// - Wait 4096 input clocks, then core runs
// - Reset pin outputs unless control bit 0 set
// - New multiplier and divider accepted only in run state
// - Oscillator is 2 x multiplier; core divides it
// - Post-divider is 2, 4, 8 or 16; 2 in reset
// - Multiplier comes from start-ratio pins during reset
// - Input divide enable halves the PLL input
// - Memory, core and serial ports use derived clock
// - Running reset spares PLL, SDRAM, no boot
package ccprc_pkg;
   localparam logic [3:0] ADDR_POWER_MANAGEMENT_CONTROL        = 4'h0;
   localparam logic [3:0] ADDR_RUNRST_CTL   = 4'h1;
   localparam logic [3:0] ADDR_STATUS       = 4'h2;
   localparam logic [3:0] ADDR_RUNRST_CMD   = 4'h3;
   localparam int         MULT_W            = 7;
   localparam int         POWER_MANAGEMENT_CONTROL_MULT_LSB    = 0;
   localparam int         POWER_MANAGEMENT_CONTROL_DIV_LSB     = 7;
   localparam int         POWER_MANAGEMENT_CONTROL_INPUT_DIVIDE_ENABLE_BIT   = 9;
   localparam int         RUNRST_EN_BIT     = 0;
   localparam logic [1:0] RATIO_8           = 2'h0;
   localparam logic [1:0] RATIO_32          = 2'h1;
   localparam logic [1:0] RATIO_16          = 2'h2;
   localparam logic [1:0] DIV_SEL_RESET     = 2'h0;
   localparam int         LOCK_CYCLES       = 4096;
   localparam int         CNT_W             = 13;
   localparam int         RUNRST_PULSE      = 4;
   typedef enum logic [1:0] {ccprc_st_reset, ccprc_st_lock, ccprc_st_run} ccprc_state_t;
endpackage

/* File: rtl/ccprc_divider.sv */
`timescale 1ns/10ps
`default_nettype none
// Divides clk by 1,2,4 or 8 (half of the post-divider 2,4,8 or 16) to make the core clock enable
module ccprc_divider (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic [1:0] div_sel,
   output logic            core_tick
);
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   wire  [3:0] limit = 4'h1 << div_sel; // Half of 2,4,8,16
   wire        wrap  = (cnt_q >= limit - 4'h1);
   assign cnt_d = wrap ? 4'h0 : cnt_q + 4'h1;
   // Tick once per divider period; range change mid-count wraps safely via >=
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cnt_q     <= 4'h0;
         core_tick <= 1'b0;
      end else begin
         cnt_q     <= cnt_d;
         core_tick <= wrap;
      end
   end
endmodule
`default_nettype wire

/* File: rtl/ccprc_top.sv */
`timescale 1ns/10ps
`default_nettype none
// Start-up clock and reset sequencer; clk stands for the input clock
module ccprc_top #(
   parameter int LOCK_CYCLES = ccprc_pkg::LOCK_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic [1:0]  start_ratio_pins,
   input  wire logic [2:0]  boot_select_pins,
   input  wire logic        reset_pin_in,
   output logic             reset_pin_out,
   output logic             reset_pin_oe,
   input  wire logic [3:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic [31:0]      rdata,
   output logic             core_run,
   output logic             core_reset_n,
   output logic             periph_reset_n,
   output logic             boot_req,
   output logic [2:0]       boot_mode,
   output logic [ccprc_pkg::MULT_W-1:0] pll_multiplier,
   output logic [4:0]       pll_post_divider,
   output logic             input_divide_enable,
   output logic [8:0]       oscillator_ratio,
   output logic             core_tick
);
   // Strap decode, used to load the multiplier in the reset state
   function automatic logic [ccprc_pkg::MULT_W-1:0] ratio_mult(input logic [1:0] r);
      case (r)
         ccprc_pkg::RATIO_8:  ratio_mult = 7'h04;
         ccprc_pkg::RATIO_32: ratio_mult = 7'h10;
         ccprc_pkg::RATIO_16: ratio_mult = 7'h08;
         default:             ratio_mult = 7'h04; // Reserved code falls back to slowest
      endcase
   endfunction

   ccprc_pkg::ccprc_state_t state_q;
   ccprc_pkg::ccprc_state_t state_d;
   logic [ccprc_pkg::CNT_W-1:0]  lock_cnt_q;
   logic [ccprc_pkg::MULT_W-1:0] mult_q;
   logic [1:0]                   div_q;
   logic                         input_divide_enable_q;
   logic                         runrst_en_q;
   logic [2:0]                   runrst_cnt_q;
   logic                         run_reset_q;
   logic                         boot_req_q;
   logic [2:0]                   boot_mode_q;
   logic [1:0]                   input_divide_enable_ph_q;
   wire                          raw_tick;

   // Register map, all words 32 bits wide
   // Offset 0: PLL settings, writable only once running
   //    Bits 6:0 multiplier, 8:7 divider code, 9 input halving
   //    Divider codes 0..3 select 2, 4, 8 and 16
   //    Writes before the run state are dropped on purpose
   //    Reason: straps own the multiplier until lock ends
   // Offset 1: running reset control, bit 0 only
   //    Clear: reset pin is driven as an output
   //    Set: pin becomes an input, low asks for running reset
   //    Writable in any state, survives running reset
   // Offset 2: status, read only
   //    Bit 7 running reset active
   //    Bits 6:4 boot mode caught at release
   //    Bits 3:2 live strap levels, not a stored copy
   //    Bits 1:0 sequencer state
   // Offset 3: write bit 0 high for a software running reset
   //    Reads of this offset return zero
   // Unmapped offsets read zero and ignore writes
   //
   // Start-up sequence after hard reset release
   //    One cycle in reset state, straps sampled there
   //    Then a fixed lock wait, counted in input clocks
   //    Then run: core, peripherals and tick enabled
   //    Boot request pulses once, at the end of the wait
   // Limitation: straps must hold through the reset state
   //    A strap change later is seen only in status
   //
   // Running reset
   //    Requested by the pin when enabled, or by command
   //    Only honoured in the run state
   //    Stretched by a short counter after the request ends
   //    Drops core, peripheral resets and core run
   //    Leaves PLL settings, boot mode and sequencer alone
   //    No boot request follows it
   //
   // Clocking model
   //    The oscillator and PLL are modelled as enables
   //    The divider child makes one raw tick per period
   //    Input halving passes every other raw tick
   //    Trade-off: no real clock edges, so no glitch risk
   //    Software keeps multiplier products within range
   //
   // Reset pin
   //    Level is low until the run state is reached
   //    Output enable follows the control bit only
   //    The board pull-up holds it high when released

   // Register decode
   wire in_run     = (state_q == ccprc_pkg::ccprc_st_run);
   wire wr_power_management_control   = wr && addr == ccprc_pkg::ADDR_POWER_MANAGEMENT_CONTROL && in_run;
   wire wr_rrctl   = wr && addr == ccprc_pkg::ADDR_RUNRST_CTL;
   wire wr_rrcmd   = wr && addr == ccprc_pkg::ADDR_RUNRST_CMD && wdata[0];
   wire lock_done  = (lock_cnt_q == LOCK_CYCLES[ccprc_pkg::CNT_W-1:0] - 13'h0001);
   wire run_req    = (runrst_en_q && !reset_pin_in) || wr_rrcmd;
   wire [31:0] power_management_control_rd = {22'h0, input_divide_enable_q, div_q, mult_q};

   // Sequencer: reset, lock wait, run
   always_comb begin
      state_d = state_q;
      case (state_q)
         ccprc_pkg::ccprc_st_reset: state_d = ccprc_pkg::ccprc_st_lock;
         ccprc_pkg::ccprc_st_lock:  if (lock_done) state_d = ccprc_pkg::ccprc_st_run;
         ccprc_pkg::ccprc_st_run:   state_d = ccprc_pkg::ccprc_st_run;
         default:                   state_d = ccprc_pkg::ccprc_st_reset;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_q    <= ccprc_pkg::ccprc_st_reset;
         lock_cnt_q <= '0;
      end else begin
         state_q    <= state_d;
         lock_cnt_q <= (state_q == ccprc_pkg::ccprc_st_lock) ? lock_cnt_q + 13'h0001 : '0;
      end
   end

   // PLL settings: straps while in reset, software afterwards
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         mult_q  <= 7'h04;
         div_q   <= ccprc_pkg::DIV_SEL_RESET;
         input_divide_enable_q <= 1'b0;
      end else if (state_q == ccprc_pkg::ccprc_st_reset) begin
         mult_q  <= ratio_mult(start_ratio_pins);
      end else if (wr_power_management_control) begin
         mult_q  <= wdata[ccprc_pkg::POWER_MANAGEMENT_CONTROL_MULT_LSB +: ccprc_pkg::MULT_W];
         div_q   <= wdata[ccprc_pkg::POWER_MANAGEMENT_CONTROL_DIV_LSB +: 2];
         input_divide_enable_q <= wdata[ccprc_pkg::POWER_MANAGEMENT_CONTROL_INPUT_DIVIDE_ENABLE_BIT];
      end
   end

   // Boot mode caught at release; running reset never re-requests boot
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         boot_req_q  <= 1'b0;
         boot_mode_q <= 3'h0;
      end else begin
         if (state_q == ccprc_pkg::ccprc_st_reset)
            boot_mode_q <= boot_select_pins; // Straps assumed stable here
         boot_req_q <= (state_q == ccprc_pkg::ccprc_st_lock) && lock_done;
      end
   end

   // Running reset: pin or command stretches a pulse to core and peripherals only
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         runrst_en_q  <= 1'b0;
         runrst_cnt_q <= 3'h0;
         run_reset_q  <= 1'b0;
      end else begin
         if (wr_rrctl)
            runrst_en_q <= wdata[ccprc_pkg::RUNRST_EN_BIT];
         if (in_run && run_req)
            runrst_cnt_q <= 3'(ccprc_pkg::RUNRST_PULSE);
         else if (runrst_cnt_q != 3'h0)
            runrst_cnt_q <= runrst_cnt_q - 3'h1;
         run_reset_q <= in_run && (run_req || runrst_cnt_q != 3'h0);
      end
   end

   // Input halving stage: phase flips per raw tick, so even periods still halve
   always_ff @(posedge clk) begin
      if (!reset_n)
         input_divide_enable_ph_q <= 2'h0;
      else
         input_divide_enable_ph_q <= input_divide_enable_ph_q + {1'b0, raw_tick};
   end

   // Read data, valid one cycle after the read strobe
   always_ff @(posedge clk) begin
      if (!reset_n)
         rdata <= 32'h0;
      else if (rd) begin
         case (addr)
            ccprc_pkg::ADDR_POWER_MANAGEMENT_CONTROL:      rdata <= power_management_control_rd;
            ccprc_pkg::ADDR_RUNRST_CTL: rdata <= {31'h0, runrst_en_q};
            ccprc_pkg::ADDR_STATUS:     rdata <= {24'h0, run_reset_q, boot_mode_q,
                                                  start_ratio_pins, state_q};
            default:                    rdata <= 32'h0;
         endcase
      end else
         rdata <= 32'h0;
   end

   ccprc_divider ccprc_divider_inst (
      .clk       (clk),
      .reset_n   (reset_n),
      .div_sel   (div_q),
      .core_tick (raw_tick)
   );

   // Outputs; core clocks (memory, core, serial ports) share core_tick
   assign core_tick           = raw_tick && in_run && (!input_divide_enable_q || input_divide_enable_ph_q[0]);
   assign core_run            = in_run && !run_reset_q;
   assign core_reset_n        = in_run && !run_reset_q;
   assign periph_reset_n      = in_run && !run_reset_q;
   assign boot_req            = boot_req_q;
   assign boot_mode           = boot_mode_q;
   assign pll_multiplier      = mult_q;
   assign pll_post_divider    = 5'h02 << div_q;
   assign input_divide_enable = input_divide_enable_q;
   assign oscillator_ratio    = {1'b0, mult_q, 1'b0}; // 2 x multiplier
   assign reset_pin_out       = in_run; // Low until the run state is reached
   assign reset_pin_oe        = !runrst_en_q;
endmodule
`default_nettype wire

/* File: sim/ccprc_checker.sv */
`timescale 1ns/10ps
`default_nettype none
// Port watcher for the sequencer; cnt_q counts cycles since the last hard reset release
module ccprc_checker #(parameter int LOCK_CYCLES = 16) (
   input wire logic                          clk, reset_n, wr, reset_pin_oe,
   input wire logic                          core_run, core_reset_n, periph_reset_n, boot_req,
   input wire logic [1:0]                    start_ratio_pins,
   input wire logic [3:0]                    addr,
   input wire logic [31:0]                   wdata,
   input wire logic [ccprc_pkg::MULT_W-1:0]  pll_multiplier,
   input wire logic [4:0]                    pll_post_divider,
   input wire logic [8:0]                    oscillator_ratio
);
   logic [15:0] cnt_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Saturates so the lock checks fire once per hard reset, never again in a long run
   always_ff @(posedge clk) cnt_q <= !reset_n ? 16'h0 : cnt_q + 16'(cnt_q != 16'hffff);
   a_lock_early: assert property (cnt_q <= LOCK_CYCLES |-> !core_run) else $error("core ran early");
   a_lock_late: assert property (cnt_q == LOCK_CYCLES + 4 |-> core_run) else $error("core late");
   a_strap_mult: assert property (boot_req |-> pll_multiplier == (start_ratio_pins == 2'h1 ? 7'h10 :
      start_ratio_pins == 2'h2 ? 7'h08 : 7'h04)) else $error("start multiplier wrong");
   a_div_boot: assert property (boot_req |-> pll_post_divider == 5'h02) else $error("start divider");
   a_div_legal: assert property (pll_post_divider inside {5'h02, 5'h04, 5'h08, 5'h10}) else $error("bad div");
   a_osc_twice: assert property (oscillator_ratio == {1'b0, pll_multiplier, 1'b0}) else $error("osc");
   a_mult_write: assert property (wr && addr == ccprc_pkg::ADDR_POWER_MANAGEMENT_CONTROL && core_run |=>
      pll_multiplier == 7'($past(wdata))) else $error("multiplier write lost");
   a_pin_input: assert property (wr && addr == ccprc_pkg::ADDR_RUNRST_CTL && wdata[0] |=> !reset_pin_oe)
      else $error("pin still driven");
   a_rr_spares: assert property ($fell(core_run) |-> $stable(pll_multiplier) && !boot_req)
      else $error("running reset hit pll");
   a_rr_both: assert property (core_reset_n == core_run && periph_reset_n == core_run) else $error("resets");
   c_boot: cover property (boot_req);
   c_rr: cover property ($fell(core_run));
   c_pin: cover property (!reset_pin_oe);
endmodule
`default_nettype wire

/* File: sim/ccprc_straps.sv */
`timescale 1ns/10ps
`default_nettype none
// Board side: straps follow the bench setting, the reset pin has a pull-up
module ccprc_straps (
   input wire logic        run_req, reset_pin_out, reset_pin_oe,
   input wire logic [1:0]  ratio_cfg,
   output logic [1:0]      start_ratio_pins,
   output logic [2:0]      boot_select_pins,
   output logic            reset_pin_in
);
   // The bench changes ratio_cfg one cycle before it asserts hard reset, so straps are settled
   assign start_ratio_pins = ratio_cfg;
   assign boot_select_pins = {1'b0, ratio_cfg};
   // Device drive wins while enabled; otherwise the pull-up unless the board pulls low
   assign reset_pin_in = reset_pin_oe ? reset_pin_out : !run_req;
endmodule
`default_nettype wire

/* File: sim/ccprc_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin mismatches++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module ccprc_top_tb;
   localparam int LK = 16;
   logic clk = 1'b0, reset_n = 1'b0, wr = 1'b0, rd = 1'b0, run_req = 1'b0;
   logic [1:0] ratio_cfg = 2'h0, start_ratio_pins;
   logic [2:0] boot_select_pins, boot_mode;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic reset_pin_in, reset_pin_out, reset_pin_oe, core_run, core_reset_n, periph_reset_n;
   logic boot_req, input_divide_enable, core_tick;
   logic [6:0] pll_multiplier;
   logic [4:0] pll_post_divider;
   logic [8:0] oscillator_ratio;
   int mismatches = 0, n_checks = 0, boots = 0, ticks = 0;
   initial forever #50 clk = !clk;
   always @(posedge clk) boots <= boots + int'(boot_req === 1'b1);
   always @(posedge clk) ticks <= ticks + int'(core_tick === 1'b1);
   ccprc_straps ccprc_straps_inst (.run_req, .reset_pin_out, .reset_pin_oe, .ratio_cfg, .start_ratio_pins,
      .boot_select_pins, .reset_pin_in);
   ccprc_top #(.LOCK_CYCLES(LK)) ccprc_top_inst (.clk, .reset_n, .start_ratio_pins, .boot_select_pins,
      .reset_pin_in, .reset_pin_out, .reset_pin_oe, .addr, .wdata, .wr, .rd, .rdata, .core_run, .core_reset_n,
      .periph_reset_n, .boot_req, .boot_mode, .pll_multiplier, .pll_post_divider, .input_divide_enable,
      .oscillator_ratio, .core_tick);
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= v; end
      @(posedge clk) wr <= 1'b0;
      @(negedge clk);
   endtask
   // Read data stands only in the cycle after the strobe, so take it mid-cycle there
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clk) begin rd <= 1'b1; addr <= a; end
      @(posedge clk) rd <= 1'b0;
      @(negedge clk) d = rdata;
   endtask
   task automatic wait_run(input logic v);
      for (int i = 0; i < 200 && core_run !== v; i++) @(negedge clk);
      if (core_run !== v) begin mismatches++; conclude(); end
   endtask
   // Hard reset under one strap setting, then the start-up clocking
   task automatic t_start(input logic [1:0] r);
      int b0;
      @(posedge clk) ratio_cfg <= r;
      @(posedge clk) reset_n <= 1'b0;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      b0 = boots;
      wait_run(1'b1);
      @(negedge clk);
      `CHK("boot pulses", 1, boots - b0)
      `CHK("pin level", 1'b1, reset_pin_out)
      `CHK("multiplier", r == 2'h1 ? 7'h10 : r == 2'h2 ? 7'h08 : 7'h04, pll_multiplier)
      `CHK("post divider", 5'h02, pll_post_divider)
      `CHK("boot mode", {1'b0, r}, boot_mode)
      `CHK("pin drives", 1'b1, reset_pin_oe)
   endtask
   // Every divider code, halving on and off, read back; unmapped reads give zero
   task automatic t_power_management_control;
      logic [31:0] v;
      int t0;
      for (int k = 0; k < 4; k++) begin
         v = 32'(((k & 1) << 9) | (k << 7) | (k + 5));
         wr_reg(ccprc_pkg::ADDR_POWER_MANAGEMENT_CONTROL, v);
         rd_reg(ccprc_pkg::ADDR_POWER_MANAGEMENT_CONTROL);
         `CHK("power_management_control", v, d)
         `CHK("multiplier", 7'(k + 5), pll_multiplier)
         `CHK("post divider", 5'(5'h02 << k), pll_post_divider)
         `CHK("oscillator", 9'(2 * (k + 5)), oscillator_ratio)
         `CHK("input halving", k[0], input_divide_enable)
      end
      // Divider 16 gives a raw tick every 8 cycles; halving keeps half of those
      @(negedge clk) t0 = ticks;
      repeat (64) @(negedge clk);
      `CHK("core ticks", 4, ticks - t0)
      rd_reg(ccprc_pkg::ADDR_STATUS);
      `CHK("status", 32'h0000003e, d)
      rd_reg(4'hf);
      `CHK("unmapped", 32'h0, d)
   endtask
   // Board pulls the pin low once it is an input; PLL settings and boot must survive
   task automatic t_runrst;
      int b0;
      logic [6:0] m;
      b0 = boots;
      m = pll_multiplier;
      wr_reg(ccprc_pkg::ADDR_RUNRST_CTL, 32'h1);
      `CHK("pin released", 1'b0, reset_pin_oe)
      @(posedge clk) run_req <= 1'b1;
      repeat (3) @(posedge clk);
      run_req <= 1'b0;
      @(negedge clk);
      `CHK("core held", 1'b0, core_run)
      `CHK("periph held", 1'b0, periph_reset_n)
      wait_run(1'b1);
      wr_reg(ccprc_pkg::ADDR_RUNRST_CMD, 32'h1);
      `CHK("core reset", 1'b0, core_reset_n)
      wait_run(1'b1);
      `CHK("pll kept", m, pll_multiplier)
      `CHK("no boot", 0, boots - b0)
   endtask
   initial begin
      for (int r = 0; r < 4; r++) t_start(2'(r));
      t_power_management_control();
      t_runrst();
      conclude();
   end
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      conclude();
   end
endmodule
bind ccprc_top ccprc_checker #(.LOCK_CYCLES(LOCK_CYCLES)) ccprc_checker_inst (.clk, .reset_n, .wr, .reset_pin_oe,
   .core_run, .core_reset_n, .periph_reset_n, .boot_req, .start_ratio_pins, .addr, .wdata, .pll_multiplier,
   .pll_post_divider, .oscillator_ratio);
`default_nettype wire
